// ==== shared/cih_pkg.sv ====
/*
 Constants, field positions and state types for the card interface
 host port: two-wire slave, control and status registers, sequencer.
 Assumes a single 200 MHz clock domain and an active-low reset.
*/
// Summary of operation
// - Bus address is 0x40 plus twice the strap value, strap 2 most significant.
// - Eighth address bit zero writes control, one reads status.
// - Write: ack address, take 8 control bits, ack, master then stops.
// - Read: ack address, send 8 status bits, master answers nack then stops.
// - Control register is all zeros after reset.
// - Run bit set starts activation with cold reset; cleared starts deactivation.
// - Bit 1 starts warm reset; hardware clears it on answer or mute.
// - Bit 2 picks card supply, one for 3 V, zero for 5 V.
// - Bit 3 halts card clock, held at the level given by bit 4.
// - Bits 5,6 divide crystal: 00 by 8, 01 by 4, 11 by 2, 10 by 1.
// - Bit 7 connects card and host data lines; else both sides float.
// - Status register reads 0x04 after reset.
// - Status bit 0 follows card detect live.
// - Status bit 1 latches detect edges, clears on read, raises interrupt.
// - Status bit 2 mirrors the card data line level.
// - Status bit 3 latches supply fault, clears on read, raises interrupt.
// - Status bit 4 latches session overload faults, clears on read, interrupts.
// - Status bit 5 sets if no answer within 40000 card clocks; clears on read or start.
// - Status bit 6 sets if answer before 400 card clocks; clears on read or start.
// - Status bit 7 is one while card supply is on.
// - Over-current during a session starts deactivation and signals the host by interrupt.
// - Run control is control bit 0; writing one starts activation.
// - Interrupt is active low and releases once flagged status is read.
// - Run bit acts only on its edges; host toggles to retry.
package cih_pkg;
   localparam logic [6:0]  I2C_BASE_ADDR = 7'h40;
   localparam logic [3:0]  I2C_BYTE_BITS = 4'h8;
   localparam int          CTL_RUN       = 0;
   localparam int          CTL_WARM      = 1;
   localparam int          CTL_V3        = 2;
   localparam int          CTL_STOP      = 3;
   localparam int          CTL_STOP_HI   = 4;
   localparam int          CTL_DIV_A     = 5;
   localparam int          CTL_DIV_B     = 6;
   localparam int          CTL_IO_EN     = 7;
   localparam int          ST_DET        = 0;
   localparam int          ST_DCHG       = 1;
   localparam int          ST_SUP        = 3;
   localparam int          ST_OVERLOAD_FAULT_FLAG       = 4;
   localparam int          ST_MUTE       = 5;
   localparam int          ST_EARLY      = 6;
   localparam logic [7:0]  CTL_RESET     = 8'h00;
   localparam logic [7:0]  STAT_RESET    = 8'h04;
   localparam logic [7:0]  ST_FLAG_MASK  = 8'h7A;
   localparam logic [7:0]  ST_ATR_FLAGS  = 8'h60;
   localparam logic [15:0] PIN_RST       = 16'h1F83;
   localparam logic [1:0]  DIV8          = 2'h0;
   localparam logic [1:0]  DIV4          = 2'h1;
   localparam logic [1:0]  DIV2          = 2'h3;
   localparam logic [1:0]  DIV1          = 2'h2;
   localparam int          ATR_MUTE_CYC  = 40000;
   localparam int          ATR_EARLY_CYC = 400;
   localparam int          CLK_NS        = 5;
   localparam int          SEQ_STEP_NS   = 1000;
   localparam int          SEQ_STEP_CYC  = (SEQ_STEP_NS + CLK_NS - 1) / CLK_NS;

   typedef enum logic [2:0] {
      I_IDLE  = 3'h0,
      I_ADDR  = 3'h1,
      I_AACK  = 3'h3,
      I_WDATA = 3'h2,
      I_WACK  = 3'h6,
      I_RDATA = 3'h7,
      I_RACK  = 3'h5
   } cih_i2c_e;

   typedef enum logic [2:0] {
      S_IDLE  = 3'h0,
      S_RAMP  = 3'h1,
      S_CLKON = 3'h3,
      S_ATR   = 3'h2,
      S_RUN   = 3'h6,
      S_WARM  = 3'h7,
      S_DOWN  = 3'h4
   } cih_seq_e;
endpackage

// ==== rtl/cih_sync.sv ====
/*
 Three-stage input synchroniser with agreement filter.
 Assumes inputs asynchronous to clk; q changes once stages two and three agree.
*/
`timescale 1ns/1ps
module cih_sync #(
   parameter int           W       = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;

   // Take new level only where the later stages agree
   wire [W-1:0] agree  = ~(s2 ^ s3);
   wire [W-1:0] next_q = (agree & s3) | (~agree & q);

   // Capture chain
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1 <= RST_VAL;
         s2 <= RST_VAL;
         s3 <= RST_VAL;
         q  <= RST_VAL;
      end else begin
         s1 <= d;
         s2 <= s1;
         s3 <= s2;
         q  <= next_q;
      end
   end
endmodule

// ==== rtl/cih_card_clk.sv ====
/*
 Card clock generator: divides the synchronised crystal level, stops
 at a chosen level, and flags each card clock rising edge.
 Assumes the crystal is already synchronised and slower than clk / 2.
*/
`timescale 1ns/1ps
module cih_card_clk import cih_pkg::*; (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       xtal,
   input  wire logic       run,
   input  wire logic       stop,
   input  wire logic       stop_hi,
   input  wire logic [1:0] div_sel,
   output logic            card_clk,
   output logic            tick
);
   logic       xtal_d;
   logic [3:0] cnt;

   // Every crystal edge advances the counter, so bit n divides by 2^n
   wire       xedge    = xtal ^ xtal_d;
   wire       src      = (div_sel == DIV1) ? cnt[0] :
                         (div_sel == DIV2) ? cnt[1] :
                         (div_sel == DIV4) ? cnt[2] : cnt[3];
   wire       next_clk = !run ? 1'b0 : (stop ? stop_hi : src);
   wire       sel8     = run && !stop && div_sel == DIV8;

   // Divider and output stage
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         xtal_d   <= 1'b0;
         cnt      <= 4'h0;
         card_clk <= 1'b0;
         tick     <= 1'b0;
      end else begin
         xtal_d   <= xtal;
         cnt      <= run ? cnt + {3'h0, xedge} : 4'h0;
         card_clk <= next_clk;
         tick     <= next_clk & ~card_clk;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_stop_level:
   assert property (run && stop ##1 run && stop |=> card_clk == $past(stop_hi))
      else $error("stopped card clock not at selected level");
   a_div8_gap:
   assert property (tick && sel8 |=> (!tick || !sel8) [*8])
      else $error("divide by eight clock too fast");
endmodule

// ==== rtl/cih_host_regs.sv ====
/*
 Host port of the card interface: two-wire slave with one control and
 one status register, card session sequencer, answer timing, fault
 flags, interrupt and the card data line bridge.
 Assumes all pins are asynchronous; open-drain lines resolved outside.
*/
`timescale 1ns/1ps
module cih_host_regs import cih_pkg::*; #(
   parameter int STEP_CYC = SEQ_STEP_CYC
) (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       scl,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe,
   input  wire logic       addr_strap_0,
   input  wire logic       addr_strap_1,
   input  wire logic       addr_strap_2,
   input  wire logic       card_detect,
   input  wire logic       supply_fault,
   input  wire logic       over_current,
   input  wire logic       over_temp,
   input  wire logic       crystal_input,
   input  wire logic [2:0] card_line_in,
   output logic      [2:0] card_line_out,
   output logic      [2:0] card_line_oe,
   input  wire logic [2:0] host_line_in,
   output logic      [2:0] host_line_out,
   output logic      [2:0] host_line_oe,
   output logic            int_n,
   output logic            card_vcc_on,
   output logic            card_vcc_3v,
   output logic            card_rst,
   output logic            card_clk
);
   logic        rs1;
   logic        rs2;
   logic [15:0] pin_s;
   logic        scl_d;
   logic        sda_d;
   logic        det_d;
   logic        io_d;
   logic        run_d;
   cih_i2c_e    i2c_st;
   logic [3:0]  bit_cnt;
   logic [7:0]  shreg;
   logic [7:0]  snap;
   logic [7:0]  ctrl;
   logic [7:0]  flags;
   cih_seq_e    seq;
   cih_seq_e    next_seq;
   logic [15:0] step_cnt;
   logic [15:0] atr_cnt;
   logic        cc_tick;
   logic [5:0]  bridge_echo;

   // Reset release through two flops
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rs1 <= 1'b0;
         rs2 <= 1'b0;
      end else begin
         rs1 <= 1'b1;
         rs2 <= rs1;
      end
   end
   wire rstn = rs2;

   // All pins pass the three-stage filter
   wire [15:0] pin_raw = {addr_strap_2, addr_strap_1, addr_strap_0, host_line_in, card_line_in,
                          crystal_input, over_temp, over_current, supply_fault, card_detect,
                          sda_in, scl};
   cih_sync #(.W(16), .RST_VAL(PIN_RST)) u_sync (
      .clk   (clk),
      .rst_n (rstn),
      .d     (pin_raw),
      .q     (pin_s)
   );
   wire       scl_s  = pin_s[0];
   wire       sda_s  = pin_s[1];
   wire       det_s  = pin_s[2];
   wire       sup_s  = pin_s[3];
   wire       ovc_s  = pin_s[4];
   wire       ovt_s  = pin_s[5];
   wire       xtal_s = pin_s[6];
   wire [2:0] card_s = pin_s[9:7];
   wire [2:0] host_s = pin_s[12:10];
   wire       io_s   = card_s[0];
   wire [7:0] status = {card_vcc_on, flags[6:3], io_s, flags[1], det_s};

   // Bus address from straps
   wire [6:0] dev_addr = I2C_BASE_ADDR + {3'h0, pin_s[15:13], 1'b0};

   // Bus edges and conditions
   wire scl_rise  = scl_s & ~scl_d;
   wire scl_fall  = ~scl_s & scl_d;
   wire i2c_start = scl_s & scl_d & sda_d & ~sda_s;
   wire i2c_stop  = scl_s & scl_d & ~sda_d & sda_s;
   wire byte_in   = scl_fall & (bit_cnt == I2C_BYTE_BITS);
   wire addr_hit  = (i2c_st == I_ADDR) & byte_in & (shreg[7:1] == dev_addr);
   wire wr_byte   = (i2c_st == I_WDATA) & byte_in;
   wire rd_done   = (i2c_st == I_RDATA) & byte_in;
   wire shift_on  = scl_rise & (i2c_st == I_ADDR || i2c_st == I_WDATA || i2c_st == I_RDATA);

   // Edge history
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
         det_d <= 1'b0;
         io_d  <= 1'b1;
         run_d <= 1'b0;
      end else begin
         scl_d <= scl_s;
         sda_d <= sda_s;
         det_d <= det_s;
         io_d  <= io_s;
         run_d <= ctrl[CTL_RUN];
      end
   end

   // Bus slave: shift on rising SCL, change SDA on falling SCL
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         i2c_st  <= I_IDLE;
         bit_cnt <= 4'h0;
         shreg   <= 8'h00;
         snap    <= STAT_RESET;
         sda_oe  <= 1'b0;
         sda_out <= 1'b0;
      end else if (i2c_start) begin
         i2c_st  <= I_ADDR;
         bit_cnt <= 4'h0;
         sda_oe  <= 1'b0;
      end else if (i2c_stop) begin
         i2c_st <= I_IDLE;
         sda_oe <= 1'b0;
      end else begin
         if (shift_on) begin
            shreg   <= {shreg[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'h1;
         end
         if (scl_fall) begin
            unique case (i2c_st)
               I_IDLE: ;
               I_ADDR: if (bit_cnt == I2C_BYTE_BITS) begin
                  i2c_st <= addr_hit ? I_AACK : I_IDLE;
                  sda_oe <= addr_hit;
               end
               I_AACK: begin
                  bit_cnt <= 4'h0;
                  if (shreg[0]) begin
                     i2c_st <= I_RDATA;
                     snap   <= status;
                     sda_oe <= ~status[7];
                  end else begin
                     i2c_st <= I_WDATA;
                     sda_oe <= 1'b0;
                  end
               end
               I_WDATA: if (bit_cnt == I2C_BYTE_BITS) begin
                  i2c_st <= I_WACK;
                  sda_oe <= 1'b1;
               end
               I_WACK: begin
                  i2c_st <= I_IDLE;
                  sda_oe <= 1'b0;
               end
               I_RDATA: if (bit_cnt == I2C_BYTE_BITS) begin
                  i2c_st <= I_RACK;
                  sda_oe <= 1'b0;
               end else begin
                  sda_oe <= ~snap[~bit_cnt[2:0]];
               end
               I_RACK: i2c_st <= I_IDLE;
            endcase
         end
      end
   end

   // Session sequencing terms
   wire in_sess    = seq != S_IDLE && seq != S_DOWN;
   wire run_rise   = ctrl[CTL_RUN] & ~run_d;
   wire run_fall   = ~ctrl[CTL_RUN] & run_d;
   wire fault      = sup_s | ovc_s | ovt_s;
   wire sess_start = (seq == S_IDLE) & run_rise & det_s & ~fault;
   wire abort      = in_sess & (run_fall | fault | ~det_s);
   wire step_done  = step_cnt == 16'(STEP_CYC - 1);
   wire answer     = (seq == S_ATR) & io_d & ~io_s & ~card_line_oe[0];
   wire early_hit  = answer & (atr_cnt < 16'(ATR_EARLY_CYC));
   wire mute_hit   = (seq == S_ATR) & ~answer & cc_tick & (atr_cnt == 16'(ATR_MUTE_CYC - 1));
   wire warm_done  = answer | mute_hit;
   wire clk_run    = seq == S_CLKON || seq == S_ATR || seq == S_RUN || seq == S_WARM;

   // Sequencer next state
   always_comb begin
      next_seq = seq;
      unique case (seq)
         S_IDLE:  if (sess_start) next_seq = S_RAMP;
         S_RAMP:  if (step_done) next_seq = S_CLKON;
         S_CLKON: if (step_done) next_seq = S_ATR;
         S_ATR:   if (warm_done) next_seq = S_RUN;
         S_RUN:   if (ctrl[CTL_WARM]) next_seq = S_WARM;
         S_WARM:  if (step_done) next_seq = S_ATR;
         S_DOWN:  if (step_done) next_seq = S_IDLE;
         default: next_seq = S_IDLE;
      endcase
      if (abort) begin
         next_seq = S_DOWN;
      end
   end

   // Sequencer state, step timer and answer timer
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         seq      <= S_IDLE;
         step_cnt <= 16'h0000;
         atr_cnt  <= 16'h0000;
      end else begin
         seq      <= next_seq;
         step_cnt <= (next_seq != seq) ? 16'h0000 : step_cnt + 16'h0001;
         atr_cnt  <= (seq == S_ATR) ? atr_cnt + {15'h0000, cc_tick} : 16'h0000;
      end
   end

   // Control register
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctrl <= CTL_RESET;
      end else if (wr_byte) begin
         ctrl <= shreg;
      end else if (warm_done) begin
         ctrl[CTL_WARM] <= 1'b0;
      end
   end

   // Sticky flags: set wins, read clears only what was reported
   wire [7:0] set_v      = {1'b0, early_hit, mute_hit, in_sess & (ovc_s | ovt_s),
                            sup_s, 1'b0, det_s ^ det_d, 1'b0};
   wire [7:0] clr_v      = (rd_done ? snap : 8'h00) | (sess_start ? ST_ATR_FLAGS : 8'h00);
   wire [7:0] next_flags = ((flags & ~clr_v) | set_v) & ST_FLAG_MASK;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         flags <= 8'h00;
         int_n <= 1'b1;
      end else begin
         flags <= next_flags;
         int_n <= ~|flags;
      end
   end

   // Card power, reset and line bridge; echo hides our own low seen back through the filter
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         card_vcc_on   <= 1'b0;
         card_vcc_3v   <= 1'b0;
         card_rst      <= 1'b0;
         bridge_echo   <= 6'h00;
         card_line_oe  <= 3'h0;
         host_line_oe  <= 3'h0;
         card_line_out <= 3'h0;
         host_line_out <= 3'h0;
      end else begin
         card_vcc_on   <= seq != S_IDLE;
         card_vcc_3v   <= ctrl[CTL_V3];
         card_rst      <= seq == S_ATR || seq == S_RUN;
         bridge_echo   <= {host_line_oe | (bridge_echo[5:3] & ~host_s), card_line_oe | (bridge_echo[2:0] & ~card_s)};
         card_line_oe  <= ctrl[CTL_IO_EN] ? (~host_s & ~host_line_oe & ~bridge_echo[5:3]) : 3'h0;
         host_line_oe  <= ctrl[CTL_IO_EN] ? (~card_s & ~card_line_oe & ~bridge_echo[2:0]) : 3'h0;
         card_line_out <= 3'h0;
         host_line_out <= 3'h0;
      end
   end

   cih_card_clk u_clk (
      .clk      (clk),
      .rst_n    (rstn),
      .xtal     (xtal_s),
      .run      (clk_run),
      .stop     (ctrl[CTL_STOP]),
      .stop_hi  (ctrl[CTL_STOP_HI]),
      .div_sel  ({ctrl[CTL_DIV_A], ctrl[CTL_DIV_B]}),
      .card_clk (card_clk),
      .tick     (cc_tick)
   );

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   a_addr_ack:
   assert property (addr_hit |=> i2c_st == I_AACK && sda_oe)
      else $error("matching address not acknowledged");
   a_dir_read:
   assert property (i2c_st == I_AACK && scl_fall && shreg[0] && !i2c_stop |=> i2c_st == I_RDATA && snap == $past(status))
      else $error("read direction did not capture status");
   a_ctrl_load:
   assert property (wr_byte |=> ctrl[7:2] == $past(shreg[7:2]) && sda_oe)
      else $error("control byte not stored or not acknowledged");
   a_nack_free:
   assert property (i2c_st == I_RACK |-> !sda_oe)
      else $error("data line held during master answer bit");
   a_cold_start:
   assert property (sess_start |=> seq == S_RAMP ##1 card_vcc_on && !card_rst)
      else $error("activation not launched");
   a_edge_only:
   assert property (seq == S_IDLE && ctrl[CTL_RUN] && run_d |=> seq == S_IDLE)
      else $error("held run bit restarted a session");
   a_warm_clear:
   assert property (warm_done && !wr_byte |=> !ctrl[CTL_WARM])
      else $error("warm reset bit not cleared");
   a_io_float:
   assert property (!ctrl[CTL_IO_EN] |=> card_line_oe == 3'h0 && host_line_oe == 3'h0)
      else $error("lines driven while disconnected");
   a_mute_set:
   assert property (mute_hit && !abort |=> flags[ST_MUTE] && seq == S_RUN)
      else $error("mute not reported");
   a_early_set:
   assert property (early_hit |=> flags[ST_EARLY])
      else $error("early answer not reported");
   a_fault_down:
   assert property (in_sess && ovc_s |=> seq == S_DOWN && flags[ST_OVERLOAD_FAULT_FLAG] ##1 !int_n)
      else $error("over-current did not deactivate and interrupt");
   a_read_keep:
   assert property (rd_done && set_v[ST_DCHG] |=> flags[ST_DCHG])
      else $error("event during read was lost");
   a_int_release:
   assert property (rd_done && set_v == 8'h00 && (flags & ~snap) == 8'h00 |=> ##1 int_n)
      else $error("interrupt not released after read");

   c_write: cover property (wr_byte ##1 i2c_st == I_WACK);
   c_read: cover property (rd_done);
   c_answer: cover property (answer ##1 seq == S_RUN);
   c_mute: cover property (mute_hit);
endmodule

// ==== bench/cih_host_master.sv ====
/*
 Two-wire bus master model of the host processor.
 Assumes sda is the resolved wire with a pull-up; changes only at clk falls.
*/
`timescale 1ns/1ps
module cih_host_master (
   input  wire logic clk,
   input  wire logic sda,
   output logic      scl,
   output logic      sda_low
);
   localparam int HALF = 12;
   // Bus idles released
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic nclk(input int n);
      repeat (n) @(negedge clk);
   endtask
   // Start or repeated start: data falls while clock high
   task automatic bus_start;
      nclk(4);
      sda_low = 1'b0;
      nclk(4);
      scl = 1'b1;
      nclk(HALF);
      sda_low = 1'b1;
      nclk(HALF);
      scl = 1'b0;
   endtask
   // Stop: data rises while clock high
   task automatic bus_stop;
      nclk(4);
      sda_low = 1'b1;
      nclk(4);
      scl = 1'b1;
      nclk(HALF);
      sda_low = 1'b0;
      nclk(HALF);
   endtask
   // One bit, data set while clock low, sampled at end of high phase
   task automatic put_bit(input logic b, output logic got);
      nclk(4);
      sda_low = !b;
      nclk(HALF);
      scl = 1'b1;
      nclk(HALF);
      got = sda;
      scl = 1'b0;
   endtask
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) put_bit(tx[i], rx[i]);
   endtask
   // Write: address, direction zero, one data byte, then stop
   task automatic write_ctrl(input logic [6:0] a, input logic [7:0] d, output logic ack);
      logic [7:0] rx;
      logic       b;
      bus_start();
      xfer({a, 1'b0}, rx);
      put_bit(1'b1, b);
      ack = !b;
      if (ack) begin
         xfer(d, rx);
         put_bit(1'b1, b);
      end
      bus_stop();
   endtask
   // Read: address, direction one, status byte, master nack, stop
   task automatic read_stat(input logic [6:0] a, output logic [7:0] d, output logic ack);
      logic b;
      bus_start();
      xfer({a, 1'b1}, d);
      put_bit(1'b1, b);
      ack = !b;
      xfer(8'hFF, d);
      put_bit(1'b1, b);
      bus_stop();
   endtask
endmodule

// ==== bench/testbench.sv ====
/*
 Self-checking bench for the card interface host port.
 Assumes the master model above and pull-ups on every open-drain line.
*/
`timescale 1ns/1ps
module testbench;
   logic       clk = 1'b0, rst_n = 1'b0, crystal_input = 1'b0;
   logic [2:0] strap = 3'h0, card_drv = 3'h7, host_drv = 3'h7;
   logic       card_detect = 1'b0, supply_fault = 1'b0, over_current = 1'b0, over_temp = 1'b0;
   logic       scl, sda_low, sda_oe, int_n, card_vcc_on, card_vcc_3v, card_rst, card_clk, sda_out;
   logic [2:0] card_line_oe, host_line_oe, card_line_out, host_line_out;
   wire        sda = !(sda_low | sda_oe);
   int         err_count = 0, check_count = 0, xc = 0;
   integer     seed = 32'h7d48;
   logic [6:0] dev;
   logic [7:0] d, v;
   logic       a;
   always #2.5 clk = ~clk;
   // Crystal at one tenth of clk
   always @(negedge clk) begin
      xc = (xc + 1) % 5;
      if (xc == 0) crystal_input <= ~crystal_input;
   end
   cih_host_master hm (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
   cih_host_regs #(.STEP_CYC(100)) uut (
      .clk(clk), .rst_n(rst_n), .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
      .addr_strap_0(strap[0]), .addr_strap_1(strap[1]), .addr_strap_2(strap[2]),
      .card_detect(card_detect), .supply_fault(supply_fault), .over_current(over_current),
      .over_temp(over_temp), .crystal_input(crystal_input),
      .card_line_in(card_drv & ~card_line_oe), .card_line_out(card_line_out), .card_line_oe(card_line_oe),
      .host_line_in(host_drv & ~host_line_oe), .host_line_out(host_line_out), .host_line_oe(host_line_oe),
      .int_n(int_n), .card_vcc_on(card_vcc_on), .card_vcc_3v(card_vcc_3v),
      .card_rst(card_rst), .card_clk(card_clk));
   task automatic test_done;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic chk(input string name, input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic nc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic rd(input logic [7:0] exp);
      hm.read_stat(dev, d, a);
      chk("read ack", a, 1'b1);
      chk("status", d, exp);
   endtask
   task automatic wr(input logic [7:0] x);
      hm.write_ctrl(dev, x, a);
      chk("write ack", a, 1'b1);
      nc(8);
   endtask
   // Bounded wait for reset (sel 0) or supply (sel 1) to reach a level
   task automatic wait_pin(input int sel, input logic lv);
      int n;
      n = 0;
      while (((sel == 0) ? card_rst : card_vcc_on) !== lv && n < 300) begin
         nc(1);
         n++;
      end
      chk("pin wait", ((sel == 0) ? card_rst : card_vcc_on), lv);
   endtask
   // Crystal model period is 10 clk, so the card clock period is 10 times the divisor
   function automatic int div_of(input logic [1:0] s);
      return (s == 2'b00) ? 8 : (s == 2'b01) ? 4 : (s == 2'b11) ? 2 : 1;
   endfunction
   // Card clock period from the second to the third rising edge after the write
   task automatic clk_period(input logic [1:0] s);
      int   k;
      int   t1;
      int   t2;
      logic p;
      k = 0;
      t1 = 0;
      t2 = 0;
      p = 1'b1;
      wr({1'b0, s[0], s[1], 5'h01});
      for (int i = 0; i < 400; i++) begin
         if (card_clk === 1'b1 && p === 1'b0) begin
            k++;
            if (k == 2) t1 = i;
            if (k == 3) t2 = i;
         end
         p = card_clk;
         nc(1);
      end
      chk("card clock period", 8'(t2 - t1), 8'(10 * div_of(s)));
   endtask
   // Watchdog
   initial begin
      #400000;
      err_count++;
      test_done();
   end
   initial begin
      dev = 7'h40;
      nc(20);
      rst_n = 1'b1;
      nc(20);
      chk("int idle", int_n, 1'b1);
      chk("volt", card_vcc_3v, 1'b0);
      rd(8'h04);
      // Every strap setting, plus a wrong address
      for (int s = 0; s < 8; s++) begin
         strap = s[2:0];
         nc(10);
         dev = 7'h40 + 7'(2 * s);
         rd(8'h04);
         dev = 7'h40 + 7'(2 * ((s + 1 + ($unsigned($random(seed)) % 7)) % 8));
         hm.read_stat(dev, d, a);
         chk("wrong addr ack", a, 1'b0);
      end
      strap = 3'($random(seed));
      nc(10);
      dev = 7'h40 + 7'(2 * strap);
      // Random supply choice and bridge enable
      for (int i = 0; i < 4; i++) begin
         v = 8'($random(seed)) & 8'hE4;
         if (i < 2) v[7] = i[0];
         wr(v);
         chk("vcc 3v", card_vcc_3v, v[2]);
         host_drv = 3'h6;
         nc(20);
         chk("bridge", card_line_oe[0], v[7]);
         host_drv = 3'h7;
         nc(20);
         card_drv = 3'h6;
         nc(20);
         chk("bridge back", host_line_oe[0], v[7]);
         card_drv = 3'h7;
         nc(20);
      end
      wr(8'h00);
      card_detect = 1'b1;
      nc(20);
      chk("int detect", int_n, 1'b0);
      rd(8'h07);
      chk("int cleared", int_n, 1'b1);
      rd(8'h05);
      supply_fault = 1'b1;
      nc(10);
      supply_fault = 1'b0;
      nc(10);
      rd(8'h0D);
      rd(8'h05);
      // Session with an early answer
      wr(8'h01);
      wait_pin(0, 1'b1);
      chk("vcc on", card_vcc_on, 1'b1);
      card_drv = 3'h6;
      nc(10);
      card_drv = 3'h7;
      nc(10);
      rd(8'hC5);
      // Every divider setting while the session runs
      for (int j = 0; j < 4; j++) begin
         clk_period(2'(j));
      end
      wr(8'h03);
      wait_pin(0, 1'b0);
      wait_pin(0, 1'b1);
      card_drv = 3'h6;
      nc(10);
      card_drv = 3'h7;
      rd(8'hC5);
      // Clock stopped high then low
      wr(8'h19);
      nc(30);
      v = 8'h00;
      for (int i = 0; i < 20; i++) begin
         v = v | {7'h0, ~card_clk};
         nc(1);
      end
      chk("stop high", v, 8'h00);
      wr(8'h09);
      nc(30);
      chk("stop low", card_clk, 1'b0);
      over_current = 1'b1;
      nc(10);
      over_current = 1'b0;
      wait_pin(1, 1'b0);
      chk("int fault", int_n, 1'b0);
      rd(8'h15);
      // Run bit acts on edges only
      wr(8'h00);
      wr(8'h01);
      wait_pin(0, 1'b1);
      wr(8'h00);
      wait_pin(1, 1'b0);
      chk("open drain data", {1'b0, sda_out, card_line_out, host_line_out}, 8'h00);
      test_done();
   end
endmodule
